// [hdl/ssf_core.sv]
/*
  Status-flag and interrupt logic of an asynchronous serial interface,
  with a minimal transmitter, receiver and baud chain around it.
  Assumes: one clock, an asynchronous active-high reset, a register master
  that keeps strobes one cycle long, and a receive pin from outside the
  clock domain (synchronised here).
*/
`timescale 1ns/1ps

// Function
// - Status flags set only by hardware, held until software clears them.
// - Normal data accesses after a flag read form the clearing sequence.
// - Switching transmitter on sets holding-empty and done flags.
// - Holding-empty flag high whenever holding register accepts a character.
// - Holding-empty interrupt requested while flag and its enable are both one.
// - Done flag marks empty queue; interrupts only with its enable set.
// - Clearing transmitter-on only requests stop; current character completes.
// - Only device reset stops the transmitter immediately.
// - Idle transmitter switched off releases pin on a bit-rate tick.
// - Switch-off mid-character finishes it and discards queued characters.
// - After the last character, done and holding-empty flags still set.
// - Five receiver flags, three can interrupt, all readable any time.
// - Receive-full set when a character moves into the holding register.
// - On overrun the new character is dropped, old one kept.
// - Overrun flag set instead of receive-full when previous unread.
// - Noise and framing flags describe held character, never interrupt.
// - Line idle after staying high for one full character time.
// - Idle flag set only on busy-to-idle transition.
// - Bit-rate clock is sample clock divided by sixteen.
module ssf_core
  import ssf_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire ssf_pkg::ssf_req_t req,
  output logic [7:0]         rd_data,
  input  wire logic          rxd,
  output ssf_pkg::ssf_pin_t  pin,
  output logic               irq
);
  import ssf_pkg::*;
  typedef struct packed {
    logic [5:0]        ctrl;
    logic [15:0]       baud;
    logic [15:0]       div_cnt;
    logic [3:0]        tx_sub;
    logic [3:0]        tx_bit;
    logic [DATA_W-1:0] tx_shift;
    ssf_tx_state_t     tx_st;
    logic [DATA_W-1:0] tx_hold;
    logic              tx_hold_full;
    logic              txd;
    logic              txd_oe;
    logic              txh;
    logic              txd_done;
    logic              txh_seen;
    logic              txd_seen;
    logic              sync1;
    logic              sync2;
    ssf_rx_state_t     rx_st;
    logic [3:0]        rx_sub;
    logic [3:0]        rx_bit;
    logic [DATA_W-1:0] rx_shift;
    logic [2:0]        rx_votes;
    logic              rx_noisy;
    logic [DATA_W-1:0] rx_hold;
    logic              rxf;
    logic              ovr;
    logic              noise;
    logic              frame;
    logic              idle;
    logic              rx_busy;
    logic [7:0]        idle_cnt;
    logic              rx_seen;
    logic [7:0]        rd_data;
    logic              irq;
  } ssf_state_t;

  ssf_state_t cur_ff;
  ssf_state_t nxt_cur;
  logic       samp_tick;
  logic       bit_tick_tx;
  logic [7:0] status_v;
  logic       mid_sample;

  // Sample clock enable from the programmable divider
  assign samp_tick   = (cur_ff.div_cnt == 16'h0000);
  // Transmit bit tick each sixteenth sample tick
  assign bit_tick_tx = samp_tick && (cur_ff.tx_sub == 4'(SSF_OVERSAMPLE - 1));
  assign mid_sample  = samp_tick && (cur_ff.rx_sub == 4'(SSF_MID_SAMPLE + 1)); // All votes in

  // Status view; every receiver flag readable at any time
  always_comb
  begin
    status_v               = 8'h00;
    status_v[SSF_ST_TXH]   = cur_ff.txh;
    status_v[SSF_ST_TXD]   = cur_ff.txd_done;
    status_v[SSF_ST_RXF]   = cur_ff.rxf;
    status_v[SSF_ST_IDLE]  = cur_ff.idle;
    status_v[SSF_ST_OVR]   = cur_ff.ovr;
    status_v[SSF_ST_NOISE] = cur_ff.noise;
    status_v[SSF_ST_FRAME] = cur_ff.frame;
  end

  // Whole next-state computation
  always_comb
  begin
    logic rd_stat;
    logic wr_data;
    logic rd_data_acc;
    logic load_tx;
    logic char_done;
    logic rx_store;
    rd_stat     = req.rd && (req.addr == SSF_OFF_STATUS);
    wr_data     = req.wr && (req.addr == SSF_OFF_DATA);
    rd_data_acc = req.rd && (req.addr == SSF_OFF_DATA);
    load_tx     = 1'b0;
    char_done   = 1'b0;
    rx_store    = 1'b0;
    nxt_cur     = cur_ff;

    // Baud divider
    if (samp_tick)
      nxt_cur.div_cnt = cur_ff.baud;
    else
      nxt_cur.div_cnt = cur_ff.div_cnt - 16'h0001;
    if (samp_tick)
      nxt_cur.tx_sub = cur_ff.tx_sub + 4'h1;

    // Register writes
    if (req.wr && req.addr == SSF_OFF_CTRL)
    begin
      nxt_cur.ctrl = req.wdata[5:0];
      if (req.wdata[SSF_CTRL_TX_ON] && !cur_ff.ctrl[SSF_CTRL_TX_ON])
      begin
        nxt_cur.txh      = 1'b1;
        nxt_cur.txd_done = 1'b1;
        nxt_cur.txd_oe   = 1'b1;
      end
    end
    if (req.wr && req.addr == SSF_OFF_BAUD)
      nxt_cur.baud = {8'h00, req.wdata};

    // Status read arms the clears for flags seen set
    if (rd_stat)
    begin
      nxt_cur.txh_seen = cur_ff.txh;
      nxt_cur.txd_seen = cur_ff.txd_done;
      nxt_cur.rx_seen  = cur_ff.rxf | cur_ff.ovr | cur_ff.idle | cur_ff.noise | cur_ff.frame;
    end

    // Data write: fills holding register and clears seen transmit flags
    if (wr_data && cur_ff.ctrl[SSF_CTRL_TX_ON] && !cur_ff.tx_hold_full)
    begin
      nxt_cur.tx_hold      = req.wdata[DATA_W-1:0];
      nxt_cur.tx_hold_full = 1'b1;
      if (cur_ff.txh_seen)
        nxt_cur.txh = 1'b0;
      if (cur_ff.txd_seen)
        nxt_cur.txd_done = 1'b0;
      nxt_cur.txh_seen = 1'b0;
      nxt_cur.txd_seen = 1'b0;
    end

    // Transmitter sequencer
    unique case (cur_ff.tx_st)
      SSF_TX_IDLE:
      begin
        nxt_cur.txd = 1'b1;
        if (!nxt_cur.ctrl[SSF_CTRL_TX_ON] && bit_tick_tx) // Same-cycle enable wins
          nxt_cur.txd_oe = 1'b0;
        if (cur_ff.tx_hold_full && cur_ff.ctrl[SSF_CTRL_TX_ON] && bit_tick_tx)
        begin
          load_tx = 1'b1;
          nxt_cur.tx_shift = cur_ff.tx_hold;
          nxt_cur.txd      = 1'b0;
          nxt_cur.tx_st    = SSF_TX_START;
        end
      end
      SSF_TX_START:
        if (bit_tick_tx)
        begin
          nxt_cur.txd    = cur_ff.tx_shift[0];
          nxt_cur.tx_bit = 4'h0;
          nxt_cur.tx_st  = SSF_TX_DATA;
        end
      SSF_TX_DATA:
        if (bit_tick_tx)
        begin
          nxt_cur.tx_shift = cur_ff.tx_shift >> 1;
          if (cur_ff.tx_bit == 4'(DATA_W - 1))
          begin
            nxt_cur.txd   = 1'b1;
            nxt_cur.tx_st = SSF_TX_STOP;
          end
          else
          begin
            nxt_cur.txd    = cur_ff.tx_shift[1];
            nxt_cur.tx_bit = cur_ff.tx_bit + 4'h1;
          end
        end
      SSF_TX_STOP:
        if (bit_tick_tx)
        begin
          // Character finishes even when tx_on was cleared meanwhile
          char_done     = 1'b1;
          nxt_cur.tx_st = SSF_TX_IDLE;
        end
    endcase

    // Holding register moves to shifter: room again in the queue
    if (load_tx)
    begin
      nxt_cur.tx_hold_full = 1'b0;
      nxt_cur.txh          = 1'b1;
    end
    // Switched off: queued characters dropped
    if (!cur_ff.ctrl[SSF_CTRL_TX_ON] && cur_ff.tx_hold_full)
      nxt_cur.tx_hold_full = 1'b0;
    // Queue drained: done flag, also after switch-off
    if (char_done && (!cur_ff.tx_hold_full || !cur_ff.ctrl[SSF_CTRL_TX_ON]))
    begin
      nxt_cur.txd_done = 1'b1;
      nxt_cur.txh      = 1'b1;
    end

    // Receive pin synchroniser
    nxt_cur.sync1 = rxd;
    nxt_cur.sync2 = cur_ff.sync1;

    // Receiver with 3-sample majority around bit centre
    if (samp_tick)
      nxt_cur.rx_sub = cur_ff.rx_sub + 4'h1;
    if (samp_tick && cur_ff.rx_sub >= 4'(SSF_MID_SAMPLE - 2) && cur_ff.rx_sub <= 4'(SSF_MID_SAMPLE))
      nxt_cur.rx_votes = {cur_ff.rx_votes[1:0], cur_ff.sync2};
    unique case (cur_ff.rx_st)
      SSF_RX_IDLE:
        if (!cur_ff.sync2 && cur_ff.ctrl[SSF_CTRL_RX_ON])
        begin
          nxt_cur.rx_sub   = 4'h0;
          nxt_cur.rx_noisy = 1'b0;
          nxt_cur.rx_st    = SSF_RX_START;
        end
      SSF_RX_START:
        if (mid_sample)
          nxt_cur.rx_st = cur_ff.rx_votes[1] ? SSF_RX_IDLE : SSF_RX_DATA;
      SSF_RX_DATA:
        if (mid_sample)
        begin
          nxt_cur.rx_shift = {(cur_ff.rx_votes[1] & cur_ff.rx_votes[0]) |
                              (cur_ff.rx_votes[1] & cur_ff.rx_votes[2]) |
                              (cur_ff.rx_votes[0] & cur_ff.rx_votes[2]),
                              cur_ff.rx_shift[DATA_W-1:1]};
          if ((|cur_ff.rx_votes) && !(&cur_ff.rx_votes)) // Any disagreement among votes
            nxt_cur.rx_noisy = 1'b1;
          nxt_cur.rx_bit = cur_ff.rx_bit + 4'h1;
          if (cur_ff.rx_bit == 4'(DATA_W - 1))
            nxt_cur.rx_st = SSF_RX_STOP;
        end
      SSF_RX_STOP:
        if (mid_sample)
        begin
          rx_store       = 1'b1;
          nxt_cur.rx_st  = SSF_RX_IDLE;
        end
    endcase
    if (cur_ff.rx_st == SSF_RX_IDLE)
      nxt_cur.rx_bit = 4'h0;

    // Receive data read clears all five receiver flags once a status read saw any set
    if (rd_data_acc && cur_ff.rx_seen)
    begin
      nxt_cur.rxf     = 1'b0;
      nxt_cur.ovr     = 1'b0;
      nxt_cur.idle    = 1'b0;
      nxt_cur.noise   = 1'b0;
      nxt_cur.frame   = 1'b0;
      nxt_cur.rx_seen = 1'b0;
    end
    // Completed character: set wins over a same-cycle clear
    if (rx_store)
    begin
      if (cur_ff.rxf && !(rd_data_acc && cur_ff.rx_seen))
        nxt_cur.ovr = 1'b1;
      else
      begin
        nxt_cur.rx_hold = cur_ff.rx_shift;
        nxt_cur.rxf     = 1'b1;
        nxt_cur.noise   = cur_ff.rx_noisy;
        nxt_cur.frame   = !cur_ff.rx_votes[1];
      end
    end

    // Idle detection: one character of continuous high after activity
    if (!cur_ff.sync2)
    begin
      nxt_cur.idle_cnt = 8'h00;
      nxt_cur.rx_busy  = 1'b1;
    end
    else if (samp_tick && cur_ff.rx_busy)
    begin
      if (cur_ff.idle_cnt == 8'(SSF_CHAR_BITS * SSF_OVERSAMPLE - 1))
      begin
        nxt_cur.idle    = 1'b1;
        nxt_cur.rx_busy = 1'b0;
      end
      else
        nxt_cur.idle_cnt = cur_ff.idle_cnt + 8'h01;
    end

    // Read data one cycle after strobe
    nxt_cur.rd_data = 8'h00;
    if (req.rd)
      unique case (req.addr)
        SSF_OFF_CTRL:   nxt_cur.rd_data = {2'b00, cur_ff.ctrl};
        SSF_OFF_STATUS: nxt_cur.rd_data = status_v;
        SSF_OFF_DATA:   nxt_cur.rd_data = 8'(cur_ff.rx_hold);
        SSF_OFF_BAUD:   nxt_cur.rd_data = cur_ff.baud[7:0];
        default:        nxt_cur.rd_data = 8'h00;
      endcase

    // Interrupt request; noise and framing never take part
    nxt_cur.irq = (nxt_cur.txh      & nxt_cur.ctrl[SSF_CTRL_TXH_IRQ_EN]) |
                  (nxt_cur.txd_done & nxt_cur.ctrl[SSF_CTRL_TXD_IRQ_EN]) |
                  ((nxt_cur.rxf | nxt_cur.ovr) & nxt_cur.ctrl[SSF_CTRL_RXF_IRQ_EN]) |
                  (nxt_cur.idle & nxt_cur.ctrl[SSF_CTRL_IDLE_IRQ_EN]);
  end

  // State register; reset abandons any character at once
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cur_ff       <= '0;
      cur_ff.ctrl  <= SSF_CTRL_RST;
      cur_ff.baud  <= SSF_BAUD_RST;
      cur_ff.tx_st <= SSF_TX_IDLE;
      cur_ff.rx_st <= SSF_RX_IDLE;
      cur_ff.txd   <= 1'b1;
      cur_ff.sync1 <= 1'b1;
      cur_ff.sync2 <= 1'b1;
    end
    else
      cur_ff <= nxt_cur;
  end

  assign rd_data    = cur_ff.rd_data;
  assign pin.txd    = cur_ff.txd;
  assign pin.txd_oe = cur_ff.txd_oe;
  assign irq        = cur_ff.irq;

  // Checks
  property p_ovr_keeps_hold;
    @(posedge core_clk) disable iff (rst)
      (cur_ff.ovr && !$past(cur_ff.ovr)) |-> $stable(cur_ff.rx_hold);
  endproperty
  a_ovr_keeps_hold: assert property (p_ovr_keeps_hold) else $error("hold changed on overrun");
  property p_irq_or;
    @(posedge core_clk) disable iff (rst)
      (cur_ff.txh && cur_ff.ctrl[SSF_CTRL_TXH_IRQ_EN]) |-> irq;
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("missing interrupt");
  property p_nf_no_irq;
    @(posedge core_clk) disable iff (rst)
      (cur_ff.ctrl[5:2] == 4'h0) |-> !irq;
  endproperty
  a_nf_no_irq: assert property (p_nf_no_irq) else $error("interrupt without enable");
  property p_tx_on_sets;
    @(posedge core_clk) disable iff (rst)
      (req.wr && req.addr == SSF_OFF_CTRL && req.wdata[0] && !cur_ff.ctrl[0])
        |=> (cur_ff.txh && cur_ff.txd_done);
  endproperty
  a_tx_on_sets: assert property (p_tx_on_sets) else $error("flags not set on enable");
  property p_done_sets;
    @(posedge core_clk) disable iff (rst)
      (cur_ff.tx_st == SSF_TX_STOP && bit_tick_tx && !cur_ff.tx_hold_full) |=> cur_ff.txd_done;
  endproperty
  a_done_sets: assert property (p_done_sets) else $error("done flag missing");
  property p_off_drops;
    @(posedge core_clk) disable iff (rst)
      (!cur_ff.ctrl[0] && cur_ff.tx_hold_full) |=> !cur_ff.tx_hold_full;
  endproperty
  a_off_drops: assert property (p_off_drops) else $error("queue kept after off");
  property p_oe_on_tick;
    @(posedge core_clk) disable iff (rst)
      $fell(cur_ff.txd_oe) |-> $past(bit_tick_tx);
  endproperty
  a_oe_on_tick: assert property (p_oe_on_tick) else $error("pin release off tick");
  property p_stop_completes;
    @(posedge core_clk) disable iff (rst)
      (cur_ff.tx_st == SSF_TX_DATA && $fell(cur_ff.ctrl[0])) |=> cur_ff.tx_st != SSF_TX_IDLE;
  endproperty
  a_stop_completes: assert property (p_stop_completes) else $error("char abandoned");

endmodule

// [hdl/ssf_pkg.sv]
/*
  Package for the serial status-flag block: register offsets, field positions,
  reset values, timing constants and the state carriers.
  Assumes a single 40 MHz core clock and a plain strobe register port.
*/
package ssf_pkg;

  // Register offsets (byte addresses on the plain register port)
  localparam logic [3:0] SSF_OFF_CTRL   = 4'h0;
  localparam logic [3:0] SSF_OFF_STATUS = 4'h4;
  localparam logic [3:0] SSF_OFF_DATA   = 4'h8;
  localparam logic [3:0] SSF_OFF_BAUD   = 4'hC;

  // Control field positions
  localparam int SSF_CTRL_TX_ON       = 0;
  localparam int SSF_CTRL_RX_ON       = 1;
  localparam int SSF_CTRL_TXH_IRQ_EN  = 2;
  localparam int SSF_CTRL_TXD_IRQ_EN  = 3;
  localparam int SSF_CTRL_RXF_IRQ_EN  = 4;
  localparam int SSF_CTRL_IDLE_IRQ_EN = 5;

  // Status field positions
  localparam int SSF_ST_TXH  = 7;
  localparam int SSF_ST_TXD  = 6;
  localparam int SSF_ST_RXF  = 5;
  localparam int SSF_ST_IDLE = 4;
  localparam int SSF_ST_OVR  = 3;
  localparam int SSF_ST_NOISE = 2;
  localparam int SSF_ST_FRAME = 1;

  // Reset values
  localparam logic [5:0]  SSF_CTRL_RST = 6'h00;
  localparam logic [15:0] SSF_BAUD_RST = 16'h0001;

  // Timing: sample clock is sixteen times the bit rate
  localparam int SSF_OVERSAMPLE  = 16;
  localparam int SSF_MID_SAMPLE  = 8;
  localparam int SSF_CHAR_BITS   = 10;
  localparam int SSF_CLK_HZ      = 40000000;

  typedef enum logic [3:0] {
    SSF_TX_IDLE  = 4'b0001,
    SSF_TX_START = 4'b0010,
    SSF_TX_DATA  = 4'b0100,
    SSF_TX_STOP  = 4'b1000
  } ssf_tx_state_t;

  typedef enum logic [3:0] {
    SSF_RX_IDLE  = 4'b0001,
    SSF_RX_START = 4'b0010,
    SSF_RX_DATA  = 4'b0100,
    SSF_RX_STOP  = 4'b1000
  } ssf_rx_state_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ssf_req_t;

  // Pin-side carrier
  typedef struct packed {
    logic txd;
    logic txd_oe;
  } ssf_pin_t;

endpackage

// [verification/ssf_remote.sv]
/*
  Remote serial partner: sends frames into the receive pin and decodes
  frames seen on the transmit pin into a queue.
  Assumes 8 data bits LSB first, one start and one stop bit, and a bit
  period given in core clock cycles.
*/
`timescale 1ns/1ps

module ssf_remote
#(
  parameter int BIT_CYC = 32
)
(
  input  wire logic core_clk,
  input  wire logic txd,
  input  wire logic txd_oe,
  output logic      rxd
);
  logic [7:0] rq[$];
  logic [7:0] sh;

  // Line rests high between frames, as the pull-up would leave it
  initial rxd = 1'b1;

  // One frame; a low stop bit lets a test provoke a framing error
  task automatic send(input logic [7:0] d, input logic bad_stop);
    logic [9:0] fr;
    fr = {~bad_stop, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge core_clk);
      rxd <= fr[i];
      repeat (BIT_CYC - 1) @(posedge core_clk);
    end
    @(posedge core_clk);
    rxd <= 1'b1;
  endtask

  // Sample mid-bit; a frame cut short by reset still lands, bench flushes it
  always
  begin
    @(negedge txd);
    if (txd_oe === 1'b1)
    begin
      repeat (BIT_CYC / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYC) @(posedge core_clk);
        sh[i] = txd;
      end
      repeat (BIT_CYC) @(posedge core_clk);
      rq.push_back(sh);
    end
  end
endmodule

// [verification/ssf_core_bench.sv]
/*
  Self-checking bench for the serial status-flag block: register reads are
  noted in a queue and compared one cycle later by a monitor process.
  Assumes the baud register stays at its reset value of 1.
*/
`timescale 1ns/1ps

module ssf_core_bench;
  import ssf_pkg::*;

  localparam int BIT_CYC  = SSF_OVERSAMPLE * 2; // Sample tick every 2 cycles
  localparam int CHAR_CYC = BIT_CYC * SSF_CHAR_BITS;

  logic       core_clk;
  logic       rst;
  ssf_req_t   req;
  logic [7:0] rd_data;
  logic       rxd;
  ssf_pin_t   pin;
  logic       irq;
  logic       rd_seen;
  logic [7:0] eq[$];
  logic [7:0] mq[$];
  logic [7:0] d0;
  logic [7:0] d1;
  logic [7:0] ctl[3] = '{8'h05, 8'h01, 8'h09};
  logic [7:0] exi[3] = '{8'h01, 8'h00, 8'h01};
  int         n_fail;
  int         cmp_count;
  int         cyc_n;

  // 40 MHz core clock
  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;

  ssf_core #(.DATA_W(8)) uut (
    .core_clk (core_clk),
    .rst      (rst),
    .req      (req),
    .rd_data  (rd_data),
    .rxd      (rxd),
    .pin      (pin),
    .irq      (irq)
  );

  ssf_remote #(.BIT_CYC(BIT_CYC)) u_rem (
    .core_clk (core_clk),
    .txd      (pin.txd),
    .txd_oe   (pin.txd_oe),
    .rxd      (rxd)
  );

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Every bus signal moves together right after an edge
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask

  task automatic cyc(input int n);
    repeat (n) bus(1'b0, 1'b0, 4'h0, 8'h00);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    eq.push_back(e & m);
    mq.push_back(m);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask

  // Bounded wait for the partner to decode n frames
  task automatic wait_rq(input int n);
    int k;
    k = 0;
    while (u_rem.rq.size() < n && k < 2 * CHAR_CYC * n)
    begin
      cyc(1);
      k++;
    end
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge core_clk)
  begin
    rd_seen <= req.rd;
    if (rd_seen === 1'b1)
      chk(rd_data & mq.pop_front(), eq.pop_front());
  end

  // Hang guard, well above the few thousand cycles the sequence needs
  always @(posedge core_clk)
  begin
    cyc_n++;
    if (cyc_n == 40000)
    begin
      n_fail++;
      summarize();
    end
  end

  // Main sequence
  initial
  begin
    rst = 1'b1;
    req = '0;
    rd_seen = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    cyc_n = 0;
    void'($urandom(32'ha570));
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rd(SSF_OFF_CTRL, 8'h3F, 8'h00);
    rd(SSF_OFF_BAUD, 8'hFF, 8'h01);
    rd(4'h2, 8'hFF, 8'h00);
    wr(SSF_OFF_CTRL, 8'h01);
    cyc(2);
    chk({7'h0, pin.txd_oe}, 8'h01);
    rd(SSF_OFF_STATUS, 8'hC0, 8'hC0);
    for (int i = 0; i < 3; i++)
    begin
      wr(SSF_OFF_CTRL, ctl[i]);
      cyc(3);
      chk({7'h0, irq}, exi[i]);
    end
    // Two characters back to back: one shifting, one queued
    wr(SSF_OFF_CTRL, 8'h01);
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    rd(SSF_OFF_STATUS, 8'hC0, 8'hC0);
    wr(SSF_OFF_DATA, d0);
    // Second write only once the first has moved to the shifter
    cyc(BIT_CYC + 8);
    rd(SSF_OFF_STATUS, 8'hC0, 8'h80);
    wr(SSF_OFF_DATA, d1);
    rd(SSF_OFF_STATUS, 8'hC0, 8'h00);
    wait_rq(2);
    chk(u_rem.rq.pop_front(), d0);
    chk(u_rem.rq.pop_front(), d1);
    cyc(BIT_CYC);
    rd(SSF_OFF_STATUS, 8'hC0, 8'hC0);
    // Switch off mid-character with a second one waiting
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    wr(SSF_OFF_DATA, d0);
    // Switch off inside the first data bit of the first character
    cyc(2 * BIT_CYC + 8);
    wr(SSF_OFF_DATA, d1);
    wr(SSF_OFF_CTRL, 8'h00);
    cyc(BIT_CYC);
    chk({7'h0, pin.txd_oe}, 8'h01);
    wait_rq(1);
    chk(u_rem.rq.pop_front(), d0);
    cyc(CHAR_CYC + BIT_CYC);
    chk({7'h0, pin.txd_oe}, 8'h00);
    chk(8'(u_rem.rq.size()), 8'h00);
    rd(SSF_OFF_STATUS, 8'hC0, 8'hC0);
    // Idle transmitter switched off gives the pin back within a bit
    wr(SSF_OFF_CTRL, 8'h01);
    cyc(4);
    wr(SSF_OFF_CTRL, 8'h00);
    cyc(BIT_CYC + 4);
    chk({7'h0, pin.txd_oe}, 8'h00);
    // Plain receive with the full-flag request enabled
    wr(SSF_OFF_CTRL, 8'h12);
    d0 = 8'($urandom);
    // Strobe must drop first: the line task never touches the bus
    cyc(1);
    u_rem.send(d0, 1'b0);
    cyc(20);
    rd(SSF_OFF_STATUS, 8'h3E, 8'h20);
    chk({7'h0, irq}, 8'h01);
    rd(SSF_OFF_DATA, 8'hFF, d0);
    rd(SSF_OFF_STATUS, 8'h20, 8'h00);
    // Overrun: second character lost, first one kept
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    cyc(1);
    u_rem.send(d0, 1'b0);
    u_rem.send(d1, 1'b0);
    cyc(20);
    rd(SSF_OFF_STATUS, 8'h28, 8'h28);
    rd(SSF_OFF_DATA, 8'hFF, d0);
    // Framing error never requests an interrupt
    wr(SSF_OFF_CTRL, 8'h22); // Idle request armed so a leak would show
    d0 = 8'($urandom);
    cyc(1);
    u_rem.send(d0, 1'b1);
    cyc(20);
    chk({7'h0, irq}, 8'h00);
    rd(SSF_OFF_STATUS, 8'h02, 8'h02);
    rd(SSF_OFF_DATA, 8'hFF, d0);
    // Idle detection after one character time, once only
    wr(SSF_OFF_CTRL, 8'h22);
    d0 = 8'($urandom);
    cyc(1);
    u_rem.send(d0, 1'b0);
    cyc(20);
    rd(SSF_OFF_STATUS, 8'h10, 8'h00);
    cyc(CHAR_CYC + 40);
    chk({7'h0, irq}, 8'h01);
    rd(SSF_OFF_STATUS, 8'h10, 8'h10);
    rd(SSF_OFF_DATA, 8'hFF, d0);
    cyc(CHAR_CYC + 80);
    rd(SSF_OFF_STATUS, 8'h10, 8'h00);
    chk({7'h0, irq}, 8'h00);
    // Reset in mid-character stops the transmitter at once
    wr(SSF_OFF_CTRL, 8'h01);
    wr(SSF_OFF_DATA, 8'($urandom));
    cyc(4 * BIT_CYC);
    @(posedge core_clk);
    rst <= 1'b1;
    cyc(2);
    chk({6'h0, pin.txd, pin.txd_oe}, 8'h02);
    @(posedge core_clk);
    rst <= 1'b0;
    cyc(CHAR_CYC + BIT_CYC);
    u_rem.rq.delete();
    chk({7'h0, pin.txd_oe}, 8'h00);
    rd(SSF_OFF_CTRL, 8'h3F, 8'h00);
    cyc(4);
    summarize();
  end
endmodule
